// >>> core/sfc_defs.svh
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
`define SFC_OP_PAGE_RD  8'hFF
`define SFC_OP_PAGE_PG  8'h41
`define SFC_OP_BLK_ER   8'h20
`define SFC_OP_ALL_ER   8'hA7
`define SFC_OP_STAT_RD  8'h70
`define SFC_OP_STAT_CLR 8'h50
`define SFC_OP_LOCK_RD  8'h71
`define SFC_OP_ID_CHK   8'hF5
`define SFC_OP_VER_OUT  8'hFB
`define SFC_OP_BOOT_OUT 8'hFC
`define SFC_CONFIRM     8'hD0
`define SFC_ID_LEN      8'h07
`define SFC_ID_LAST     9'h006
`define SFC_ID_HDR_LAST 9'h003
`define SFC_PAGE_LAST   9'h0FF
`define SFC_VER_LAST    9'h007
`define SFC_CNT_STEP    9'h001
`define SFC_BIT_STEP    3'h1
`define SFC_BIT_LAST    3'h7
`define SFC_FIFO_FULL   2'h2
`define SFC_SR_READY    7
`define SFC_SR_ERASE    5
`define SFC_SR_PROG     4
`define SFC_SR1_ID_HI   3
`define SFC_SR1_ID_LO   2
`endif

// >>> core/sfc_pkg.sv
`default_nettype none
package sfc_pkg;
	typedef enum logic [2:0] {
		FL_READ, FL_READ_BOOT, FL_LOCK_RD, FL_LOAD, FL_PROG, FL_ERASE_BLK, FL_ERASE_ALL
	} sfc_flop_t;

	typedef enum logic [3:0] {
		ST_OFF, ST_OP, ST_ADR_MID, ST_ADR_HIGH, ST_CONF, ST_PDATA,
		ST_ISSUE, ST_WAIT, ST_SEND, ST_ID_HDR, ST_ID_BYTE
	} sfc_state_t;

	typedef struct packed {
		sfc_state_t  state;
		logic [7:0]  op;
		logic [8:0]  cnt;
		logic [23:0] addr;
		logic [7:0]  tx;
		logic [7:0]  wdata;
		sfc_flop_t   flop;
		logic        req;
		logic        busy;
		logic        err_prog;
		logic        err_erase;
		logic        id_ok;
		logic        id_bad;
		logic        mode1;
		logic        ms1;
		logic        ms2;
		logic        rs1;
		logic        rs2;
		logic        rs3;
	} sfc_core_t;

	typedef struct packed {
		logic [6:0] sh;
		logic [2:0] cnt;
		logic [7:0] word;
		logic       tgl;
	} sfc_rx_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic       sout;
	} sfc_tx_t;
endpackage : sfc_pkg
`default_nettype wire

// >>> core/sfc_fifo2.sv
`default_nettype none
`include "sfc_defs.svh"
module sfc_fifo2 #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              wp;
		logic              rp;
		logic [1:0]        cnt;
	} sfc_fifo_st_t;

	sfc_fifo_st_t s_r;
	sfc_fifo_st_t s_nxt;
	logic         push;
	logic         pop;

	assign in_ready  = s_r.cnt != `SFC_FIFO_FULL;
	assign out_valid = s_r.cnt != 2'h0;
	assign out_data  = s_r.mem[s_r.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		s_nxt = s_r;
		if (push)
		begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = !s_r.wp;
		end
		if (pop)
			s_nxt.rp = !s_r.rp;
		if (push && !pop)
			s_nxt.cnt = s_r.cnt + 2'h1;
		else if (pop && !push)
			s_nxt.cnt = s_r.cnt - 2'h1;
		if (rst)
			s_nxt = '0;
	end

	always_ff @(posedge clk)
		s_r <= s_nxt;
endmodule : sfc_fifo2
`default_nettype wire

// >>> core/sfc_cmd_port.sv
// How it works
// - Clock pin high at reset release selects the synchronous command mode.
// - Incoming bits are sampled on rising edges of the transfer clock.
// - Outgoing bits change on falling edges of the transfer clock.
// - All transfers are eight-bit units, least significant bit first.
// - Busy pin low while a byte moves on the link, high while handling it or working the flash.
// - Every operation begins with an opcode byte, then its operands.
// - Status register reports ready and program/erase failures, readable by command.
// - Erase all is A7 then D0, only after ID verification or with a blank flash.
// - Lock read is 71, two address bytes, then lock byte out.
// - Version FB sends bytes two through nine, no ID needed.
// - Boot output FC, two address bytes, data out through byte 259.
// - Status read 70 sends primary then secondary byte, no ID needed.
// - A blank flash array accepts every command without ID.
// - Page read FF, two address bytes, 256 bytes out ascending.
// - Page program 41, two address bytes, 256 bytes in, then written.
// - Block erase 20, two address bytes, erases only after D0.
// - Seven-byte ID check unlocks gated commands while flash holds data.
`default_nettype none
`include "sfc_defs.svh"
module sfc_cmd_port #(
	// Arbitrary value
	parameter logic [7:0][7:0] VERSION = 64'h0123_4567_89ab_cdef
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  transfer_clock_pin,
	input  wire logic                  serial_in_pin,
	output logic                       serial_out_pin,
	output logic                       busy_handshake_pin,
	output logic                       flash_req,
	output var sfc_pkg::sfc_flop_t     flash_op,
	output logic [23:0]                flash_addr,
	output logic [7:0]                 flash_wdata,
	input  wire logic [7:0]            flash_rdata,
	input  wire logic                  flash_done,
	input  wire logic                  flash_fail,
	input  wire logic                  flash_blank,
	input  wire logic [6:0][7:0]       flash_id_code
);
	import sfc_pkg::*;

	sfc_core_t  c_r;
	sfc_core_t  c_nxt;
	sfc_rx_t    rx_r;
	sfc_rx_t    rx_nxt;
	sfc_tx_t    tx_r;
	sfc_tx_t    tx_nxt;
	logic       rx_evt;
	logic       f_iready;
	logic       f_ovalid;
	logic [7:0] f_odata;
	logic       pop;
	logic       allowed;

	function automatic logic is_wait(input sfc_state_t s);
		return s inside {ST_OP, ST_ADR_MID, ST_ADR_HIGH, ST_CONF, ST_PDATA,
			ST_SEND, ST_ID_HDR, ST_ID_BYTE};
	endfunction : is_wait

	function automatic logic gated(input logic [7:0] op);
		return !(op inside {`SFC_OP_STAT_RD, `SFC_OP_ID_CHK, `SFC_OP_VER_OUT});
	endfunction : gated

	function automatic logic [7:0] sr_main(input sfc_core_t s);
		logic [7:0] v;
		v = '0;
		v[`SFC_SR_READY] = s.state != ST_WAIT;
		v[`SFC_SR_ERASE] = s.err_erase;
		v[`SFC_SR_PROG]  = s.err_prog;
		return v;
	endfunction : sr_main

	function automatic logic [7:0] sr_aux(input sfc_core_t s);
		logic [7:0] v;
		v = '0;
		v[`SFC_SR1_ID_HI] = s.id_ok;
		v[`SFC_SR1_ID_LO] = s.id_ok;
		return v;
	endfunction : sr_aux

	// receive shifter on the rising edge
	always_comb
	begin
		rx_nxt = rx_r;
		rx_nxt.sh  = {serial_in_pin, rx_r.sh[6:1]};
		rx_nxt.cnt = rx_r.cnt + `SFC_BIT_STEP;
		if (rx_r.cnt == `SFC_BIT_LAST)
		begin
			rx_nxt.word = {serial_in_pin, rx_r.sh};
			rx_nxt.tgl  = !rx_r.tgl;
		end
	end

	// Link clock idles during reset, so its reset must not need an edge
	always_ff @(posedge transfer_clock_pin or posedge rst)
		if (rst)
			rx_r <= '0;
		else
			rx_r <= rx_nxt;

	// transmit bit changes on the falling edge
	always_comb
	begin
		tx_nxt = tx_r;
		tx_nxt.cnt  = tx_r.cnt + `SFC_BIT_STEP;
		// tx byte is held still while busy is low
		tx_nxt.sout = c_r.tx[tx_r.cnt];
	end

	always_ff @(negedge transfer_clock_pin or posedge rst)
		if (rst)
			tx_r <= '{cnt: 3'h0, sout: 1'b1};
		else
			tx_r <= tx_nxt;

	// Word stays put for eight link clocks after the toggle
	assign rx_evt = c_r.rs2 ^ c_r.rs3;

	sfc_fifo2 #(
		.W (8)
	) u_rxbuf (
		.clk       (ref_clk),
		.rst       (rst),
		.in_valid  (rx_evt),
		.in_data   (rx_r.word),
		.in_ready  (f_iready),
		.out_valid (f_ovalid),
		.out_data  (f_odata),
		.out_ready (pop)
	);

	// Bytes that arrive while the mode is off are drained and dropped
	assign pop = f_ovalid && (is_wait(c_r.state) || c_r.state == ST_OFF);
	assign allowed = c_r.id_ok || flash_blank;

	always_comb
	begin
		c_nxt = c_r;
		c_nxt.req = 1'b0;
		c_nxt.ms1 = transfer_clock_pin;
		c_nxt.ms2 = c_r.ms1;
		c_nxt.rs1 = rx_r.tgl;
		c_nxt.rs2 = c_r.rs1;
		c_nxt.rs3 = c_r.rs2;
		case (c_r.state)
			ST_OFF:
				if (c_r.mode1)
					c_nxt.state = ST_OP;
			ST_OP:
				if (pop)
				begin
					c_nxt.op  = f_odata;
					c_nxt.cnt = '0;
					if (gated(f_odata) && !allowed)
						c_nxt.state = ST_OP;
					else if (f_odata == `SFC_OP_STAT_RD)
					begin
						c_nxt.tx    = sr_main(c_r);
						c_nxt.state = ST_SEND;
					end
					else if (f_odata == `SFC_OP_VER_OUT)
					begin
						c_nxt.tx    = VERSION[0];
						c_nxt.state = ST_SEND;
					end
					else if (f_odata == `SFC_OP_ID_CHK)
					begin
						c_nxt.id_bad = 1'b0;
						c_nxt.state  = ST_ID_HDR;
					end
					else if (f_odata == `SFC_OP_ALL_ER)
						c_nxt.state = ST_CONF;
					else if (f_odata == `SFC_OP_STAT_CLR)
					begin
						c_nxt.err_prog  = 1'b0;
						c_nxt.err_erase = 1'b0;
					end
					else if (f_odata inside {`SFC_OP_PAGE_RD, `SFC_OP_PAGE_PG,
						`SFC_OP_BLK_ER, `SFC_OP_LOCK_RD, `SFC_OP_BOOT_OUT})
						c_nxt.state = ST_ADR_MID;
				end
			ST_ADR_MID:
				if (pop)
				begin
					c_nxt.addr[15:8] = f_odata;
					c_nxt.state = ST_ADR_HIGH;
				end
			ST_ADR_HIGH:
				if (pop)
				begin
					c_nxt.addr[23:16] = f_odata;
					c_nxt.addr[7:0]   = '0;
					c_nxt.state = ST_ISSUE;
					if (c_r.op == `SFC_OP_LOCK_RD)
						c_nxt.flop = FL_LOCK_RD;
					else if (c_r.op == `SFC_OP_BOOT_OUT)
						c_nxt.flop = FL_READ_BOOT;
					else if (c_r.op == `SFC_OP_PAGE_RD)
						c_nxt.flop = FL_READ;
					else if (c_r.op == `SFC_OP_PAGE_PG)
						c_nxt.state = ST_PDATA;
					else
						c_nxt.state = ST_CONF;
				end
			ST_CONF:
				if (pop)
				begin
					c_nxt.state = ST_OP;
					if (f_odata == `SFC_CONFIRM)
					begin
						c_nxt.flop  = (c_r.op == `SFC_OP_ALL_ER) ? FL_ERASE_ALL : FL_ERASE_BLK;
						c_nxt.state = ST_ISSUE;
					end
				end
			ST_PDATA:
				if (pop)
				begin
					c_nxt.wdata     = f_odata;
					c_nxt.addr[7:0] = c_r.cnt[7:0];
					c_nxt.flop      = FL_LOAD;
					c_nxt.state     = ST_ISSUE;
				end
			ST_ISSUE:
			begin
				c_nxt.req   = 1'b1;
				c_nxt.state = ST_WAIT;
			end
			ST_WAIT:
				if (flash_done)
				begin
					c_nxt.state = ST_OP;
					case (c_r.flop)
						FL_READ, FL_READ_BOOT, FL_LOCK_RD:
						begin
							c_nxt.tx    = flash_rdata;
							c_nxt.state = ST_SEND;
						end
						FL_LOAD:
						begin
							c_nxt.cnt   = c_r.cnt + `SFC_CNT_STEP;
							c_nxt.state = ST_PDATA;
							// Whole page in, write it
							if (c_r.cnt == `SFC_PAGE_LAST)
							begin
								c_nxt.flop  = FL_PROG;
								c_nxt.state = ST_ISSUE;
							end
						end
						FL_PROG:
							c_nxt.err_prog = c_r.err_prog || flash_fail;
						default:
							c_nxt.err_erase = c_r.err_erase || flash_fail;
					endcase
				end
			// Byte out is done when the echo byte lands
			ST_SEND:
				if (pop)
				begin
					c_nxt.state = ST_OP;
					c_nxt.cnt   = c_r.cnt + `SFC_CNT_STEP;
					if (c_r.op == `SFC_OP_STAT_RD && c_r.cnt == '0)
					begin
						c_nxt.tx    = sr_aux(c_r);
						c_nxt.state = ST_SEND;
					end
					else if (c_r.op == `SFC_OP_VER_OUT && c_r.cnt != `SFC_VER_LAST)
					begin
						c_nxt.tx    = VERSION[c_nxt.cnt[2:0]];
						c_nxt.state = ST_SEND;
					end
					else if (c_r.op inside {`SFC_OP_PAGE_RD, `SFC_OP_BOOT_OUT}
						&& c_r.cnt != `SFC_PAGE_LAST)
					begin
						c_nxt.addr[7:0] = c_nxt.cnt[7:0];
						c_nxt.state     = ST_ISSUE;
					end
				end
			ST_ID_HDR:
				if (pop)
				begin
					c_nxt.cnt = c_r.cnt + `SFC_CNT_STEP;
					if (c_r.cnt == `SFC_ID_HDR_LAST)
					begin
						c_nxt.id_bad = f_odata != `SFC_ID_LEN;
						c_nxt.cnt    = '0;
						c_nxt.state  = ST_ID_BYTE;
					end
				end
			ST_ID_BYTE:
				if (pop)
				begin
					c_nxt.cnt    = c_r.cnt + `SFC_CNT_STEP;
					c_nxt.id_bad = c_r.id_bad || (f_odata != flash_id_code[c_r.cnt[2:0]]);
					if (c_r.cnt == `SFC_ID_LAST)
					begin
						c_nxt.id_ok = !c_nxt.id_bad;
						c_nxt.state = ST_OP;
					end
				end
			default:
				c_nxt.state = ST_OFF;
		endcase
		// low only when idle for a byte
		c_nxt.busy = !is_wait(c_nxt.state) || (f_ovalid && !pop) || rx_evt || !f_iready;
		// mode taken from the clock pin at release
		if (rst)
		begin
			c_nxt       = '0;
			c_nxt.busy  = 1'b1;
			c_nxt.mode1 = c_r.ms2;
			c_nxt.ms1   = transfer_clock_pin;
			c_nxt.ms2   = c_r.ms1;
		end
	end

	always_ff @(posedge ref_clk)
		c_r <= c_nxt;

	assign serial_out_pin     = tx_r.sout;
	assign busy_handshake_pin = c_r.busy;
	assign flash_req          = c_r.req;
	assign flash_op           = c_r.flop;
	assign flash_addr         = c_r.addr;
	assign flash_wdata        = c_r.wdata;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_conf_ok;
		pop && c_r.state == ST_CONF && f_odata == `SFC_CONFIRM;
	endsequence

	sequence s_stat_cmd;
		pop && c_r.state == ST_OP && f_odata == `SFC_OP_STAT_RD;
	endsequence

	a_mode_off_busy: assert property (!c_r.mode1 |-> busy_handshake_pin && c_r.state == ST_OFF)
		else $error("busy low or active outside mode one");
	a_mode_held: assert property (##1 $stable(c_r.mode1))
		else $error("mode changed after reset release");
	a_flash_busy: assert property (c_r.state inside {ST_ISSUE, ST_WAIT} |-> busy_handshake_pin)
		else $error("busy low during flash work");
	a_tx_stable: assert property (!busy_handshake_pin ##1 !busy_handshake_pin |-> $stable(c_r.tx))
		else $error("tx byte moved while busy low");
	a_erase_after_d0: assert property (s_conf_ok |-> ##2 flash_req && flash_op inside {FL_ERASE_ALL, FL_ERASE_BLK})
		else $error("erase not issued after confirm");
	a_gate_drop: assert property (pop && c_r.state == ST_OP && gated(f_odata) && !allowed |=> c_r.state == ST_OP ##1 !flash_req)
		else $error("gated command not dropped");
	a_stat_first: assert property (s_stat_cmd |=> c_r.state == ST_SEND && c_r.tx == sr_main(c_r))
		else $error("status byte not loaded first");
	a_ver_bound: assert property (c_r.state == ST_SEND && c_r.op == `SFC_OP_VER_OUT |-> c_r.cnt <= `SFC_VER_LAST)
		else $error("version output overran");
	a_page_bound: assert property (c_r.state inside {ST_PDATA, ST_SEND} |-> c_r.cnt <= `SFC_PAGE_LAST)
		else $error("page count overran");
	a_id_source: assert property ($rose(c_r.id_ok) |-> $past(c_r.state) == ST_ID_BYTE)
		else $error("id verified outside id check");
	a_lock_out: assert property (c_r.state == ST_WAIT && flash_done && c_r.flop == FL_LOCK_RD |=> c_r.state == ST_SEND && c_r.tx == $past(flash_rdata))
		else $error("lock byte not presented");
endmodule : sfc_cmd_port
`default_nettype wire

// >>> testbench/sfc_prog_model.sv
`default_nettype none
module sfc_prog_model (
	input  wire logic ref_clk,
	output logic      transfer_clock_pin,
	output logic      serial_in_pin,
	input  wire logic serial_out_pin,
	input  wire logic busy_handshake_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int late_cnt = 0;

	initial
	begin
		transfer_clock_pin = 1'b1;
		serial_in_pin = 1'b1;
	end

	// Bounded so a stuck busy cannot hang the run
	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (busy_handshake_pin !== lvl && n < lim)
		begin
			// Busy is launched on the rising edge, look at it settled
			@(negedge ref_clk);
			n++;
		end
		if (n == lim)
			late_cnt++;
	endtask : wait_busy

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		wait_busy(1'b0, 4000);
		@(negedge ref_clk);
		// lsb first, held over rising edge
		for (int i = 0; i < 8; i++)
		begin
			serial_in_pin = tx[i];
			#8 transfer_clock_pin = 1'b0;
			#16 transfer_clock_pin = 1'b1;
			rx[i] = serial_out_pin;
			#8;
		end
		// Released line shows the inverse, not a stale bit
		serial_in_pin = ~tx[7];
		wait_busy(1'b1, 40);
	endtask : xfer

	// level of the clock pin at reset release
	task automatic strap(input logic lvl);
		transfer_clock_pin = lvl;
	endtask : strap
endmodule : sfc_prog_model
`default_nettype wire

// >>> testbench/testbench.sv
`default_nettype none
`include "sfc_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sfc_pkg::*;
	localparam logic [7:0][7:0] VERS = 64'h1122_3344_5566_7788;
	localparam logic [6:0][7:0] IDC = 56'h13_579b_df24_68ac;
	logic        ref_clk, rst, tck, sin, sout, busy, flash_req, flash_done, flash_fail, flash_blank;
	sfc_flop_t   flash_op, last_op;
	logic [23:0] flash_addr;
	logic [7:0]  flash_wdata, flash_rdata, rx;
	logic [15:0] wsum;
	int          req_cnt, base, error_cnt, samples_checked;

	sfc_cmd_port #(.VERSION(VERS)) uut (
		.ref_clk(ref_clk), .rst(rst), .transfer_clock_pin(tck), .serial_in_pin(sin),
		.serial_out_pin(sout), .busy_handshake_pin(busy), .flash_req(flash_req),
		.flash_op(flash_op), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_rdata(flash_rdata), .flash_done(flash_done), .flash_fail(flash_fail),
		.flash_blank(flash_blank), .flash_id_code(IDC));

	sfc_prog_model pm (
		.ref_clk(ref_clk), .transfer_clock_pin(tck), .serial_in_pin(sin),
		.serial_out_pin(sout), .busy_handshake_pin(busy));

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Flash answers one cycle after each request
	always @(negedge ref_clk)
	begin
		flash_done <= 1'b0;
		if (flash_req === 1'b1)
		begin
			req_cnt <= req_cnt + 1;
			last_op <= flash_op;
			if (flash_op === FL_LOAD)
				wsum <= wsum + 16'(flash_wdata);
			flash_rdata <= flash_addr[7:0] ^ flash_addr[15:8];
			flash_done <= 1'b1;
		end
	end

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check8

	task automatic check24(input string what, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check24

	task automatic send(input logic [7:0] b);
		pm.xfer(b, rx);
	endtask : send

	task automatic stat(input logic [7:0] ep, input logic [7:0] es);
		send(`SFC_OP_STAT_RD);
		send(8'h00);
		check8("primary status", ep, rx);
		send(8'h00);
		check8("secondary status", es, rx);
	endtask : stat

	task automatic t_refuse;
		base = req_cnt;
		stat(8'h80, 8'h00);
		send(`SFC_OP_LOCK_RD);
		stat(8'h80, 8'h00);
		send(`SFC_OP_ALL_ER);
		send(`SFC_CONFIRM);
		stat(8'h80, 8'h00);
		check24("request count", 24'(base), 24'(req_cnt));
		$display("test refuse done");
	endtask : t_refuse

	task automatic t_blank;
		@(negedge ref_clk);
		flash_blank = 1'b1;
		send(`SFC_OP_LOCK_RD);
		send(8'h12);
		send(8'h0f);
		send(8'h00);
		check8("lock byte", 8'h12, rx);
		check24("lock op", 24'(FL_LOCK_RD), 24'(last_op));
		check24("lock addr", 24'h0f_1200, flash_addr);
		@(negedge ref_clk);
		flash_blank = 1'b0;
		$display("test blank done");
	endtask : t_blank

	task automatic t_version;
		send(`SFC_OP_VER_OUT);
		for (int i = 0; i < 8; i++)
		begin
			send(8'h00);
			check8("version byte", VERS[i], rx);
		end
		$display("test version done");
	endtask : t_version

	task automatic t_id;
		send(`SFC_OP_ID_CHK);
		send(8'h00);
		send(8'h00);
		send(8'h00);
		send(`SFC_ID_LEN);
		for (int i = 0; i < 7; i++)
			send(IDC[i]);
		stat(8'h80, 8'h0c);
		$display("test id done");
	endtask : t_id

	task automatic t_page(input logic [7:0] op, input sfc_flop_t kind);
		send(op);
		send(8'h3c);
		send(8'h0f);
		for (int i = 0; i < 256; i++)
		begin
			send(8'h00);
			check8("page byte", 8'(i) ^ 8'h3c, rx);
		end
		check24("read op", 24'(kind), 24'(last_op));
		check24("last addr", 24'h0f_3cff, flash_addr);
		$display("test page read done");
	endtask : t_page

	task automatic t_prog;
		base = req_cnt;
		wsum = 16'h0000;
		send(`SFC_OP_PAGE_PG);
		send(8'h3c);
		send(8'h0f);
		for (int i = 0; i < 256; i++)
			send(8'(i));
		stat(8'h80, 8'h0c);
		check24("load count", 24'd257, 24'(req_cnt - base));
		check24("prog op", 24'(FL_PROG), 24'(last_op));
		check24("data sum", 24'h00_7f80, 24'(wsum));
		$display("test program done");
	endtask : t_prog

	task automatic t_erase;
		@(negedge ref_clk);
		flash_fail = 1'b1;
		send(`SFC_OP_ALL_ER);
		send(`SFC_CONFIRM);
		stat(8'ha0, 8'h0c);
		check24("erase op", 24'(FL_ERASE_ALL), 24'(last_op));
		send(`SFC_OP_STAT_CLR);
		stat(8'h80, 8'h0c);
		@(negedge ref_clk);
		flash_fail = 1'b0;
		base = req_cnt;
		send(`SFC_OP_BLK_ER);
		send(8'h3c);
		send(8'h0f);
		send(8'h00);
		stat(8'h80, 8'h0c);
		check24("aborted erase", 24'(base), 24'(req_cnt));
		send(`SFC_OP_BLK_ER);
		send(8'h3c);
		send(8'h0f);
		send(`SFC_CONFIRM);
		stat(8'h80, 8'h0c);
		check24("block op", 24'(FL_ERASE_BLK), 24'(last_op));
		check24("block addr", 24'h0f_3c00, flash_addr);
		$display("test erase done");
	endtask : t_erase

	// Mid-run reset with the clock pin low, then back to the command mode
	task automatic t_mode;
		@(negedge ref_clk);
		rst = 1'b1;
		pm.strap(1'b0);
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
		repeat (20) @(negedge ref_clk);
		check8("busy in other mode", 8'h01, 8'(busy));
		rst = 1'b1;
		pm.strap(1'b1);
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		stat(8'h80, 8'h00);
		$display("test mode done");
	endtask : t_mode

	task automatic tally_and_finish;
		error_cnt += pm.late_cnt;
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#1_500_000;
		error_cnt++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial
	begin
		rst = 1'b1;
		flash_done = 1'b0;
		flash_fail = 1'b0;
		flash_blank = 1'b0;
		flash_rdata = 8'h00;
		last_op = FL_READ;
		wsum = 16'h0000;
		req_cnt = 0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		t_refuse();
		t_blank();
		t_version();
		t_id();
		t_page(`SFC_OP_PAGE_RD, FL_READ);
		t_page(`SFC_OP_BOOT_OUT, FL_READ_BOOT);
		t_prog();
		t_erase();
		t_mode();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
